// ==== verilog/rfafc_consts.svh ====
`ifndef RFAFC_CONSTS_SVH
`define RFAFC_CONSTS_SVH
// =====================================================================
// Register addresses
`define RFAFC_ADDR_RATE_HI      7'h6e
`define RFAFC_ADDR_RATE_LO      7'h6f
`define RFAFC_ADDR_RATE_SCALE   7'h70
`define RFAFC_ADDR_MODCTL2      7'h71
`define RFAFC_ADDR_DEV_LO       7'h72
`define RFAFC_ADDR_OFS_LO       7'h73
`define RFAFC_ADDR_OFS_HI       7'h74
`define RFAFC_ADDR_BAND         7'h75
`define RFAFC_ADDR_HOP_CH       7'h79
`define RFAFC_ADDR_HOP_STEP     7'h7a
`define RFAFC_ADDR_AFC_GEAR     7'h1d
`define RFAFC_ADDR_AFC_TIMING   7'h1e
`define RFAFC_ADDR_LIMIT        7'h2a
`define RFAFC_ADDR_CORR         7'h2b
// =====================================================================
// Reset values
`define RFAFC_RST_RATE_HI       8'h0a
`define RFAFC_RST_RATE_LO       8'h3d
`define RFAFC_RST_MODCTL2       8'h00
`define RFAFC_RST_DEV_LO        8'h20
`define RFAFC_RST_OFS           8'h00
`define RFAFC_RST_BAND          8'h35
`define RFAFC_RST_AFC_GEAR      8'h40
`define RFAFC_RST_AFC_TIMING    8'h01
`define RFAFC_RST_LIMIT         8'h00
// =====================================================================
// Field positions
`define RFAFC_DEV_MSB_BIT       2
`define RFAFC_HBSEL_BIT         5
`define RFAFC_SCALE_BIT         5
`define RFAFC_AFC_EN_BIT        6
// Rate scale exponents
`define RFAFC_RATE_SHIFT_LO     16
`define RFAFC_RATE_SHIFT_HI     21
// Rate accumulator: 1 MHz reference from 10 MHz clock
`define RFAFC_REF_DIV           4'd10
// Bit times of measurement
`define RFAFC_MEAS_BITS         4'd2
// Fixed receive bit rate for loop timing, 250 kbps
`define RFAFC_RX_RATE_WORD      16'h4000
`define RFAFC_RX_RATE_SCALE     1'b0
// Largest limiter count before the correction word saturates
`define RFAFC_LIMIT_MAX         8'd31
`define RFAFC_CORR_MAX          10'sd127
`endif

// ==== verilog/rfafc_pkg.sv ====
package rfafc_pkg;
    typedef enum logic [1:0] {RFAFC_IDLE, RFAFC_TUNE, RFAFC_TX, RFAFC_RX} rfafc_state_t;
    typedef enum logic [1:0] {RFAFC_MEAS, RFAFC_APPLY, RFAFC_SETTLE, RFAFC_HOLD} rfafc_afc_t;
endpackage : rfafc_pkg

// ==== verilog/rfafc_rate_gen.sv ====
`timescale 1ns/1ps
`include "rfafc_consts.svh"
module rfafc_rate_gen #(
    parameter int ACC_W = 22
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic [15:0] rate_word,
    input  wire logic        rate_scale,
    output logic             bit_tick
);
    if (ACC_W < `RFAFC_RATE_SHIFT_HI + 1) begin : g_acc_check
        $error("rfafc_rate_gen: ACC_W too small");
    end

    logic [3:0]       ref_cnt;
    logic [3:0]       next_ref_cnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             next_bit_tick;
    logic [ACC_W-1:0] modulus;
    logic [ACC_W:0]   sum;

    // =====================================================================
    // Phase accumulator stepped at 1 MHz
    always_comb begin
        next_ref_cnt  = ref_cnt;
        next_acc      = acc;
        next_bit_tick = 1'b0;
        modulus       = rate_scale ? ACC_W'(1) << `RFAFC_RATE_SHIFT_HI
                                   : ACC_W'(1) << `RFAFC_RATE_SHIFT_LO;
        sum           = {1'b0, acc} + {{(ACC_W-16+1){1'b0}}, rate_word};
        if (!enable) begin
            next_ref_cnt = 4'd0;
            next_acc     = '0;
        end else if (ref_cnt == `RFAFC_REF_DIV - 4'd1) begin
            next_ref_cnt = 4'd0;
            if (sum >= {1'b0, modulus}) begin
                next_acc      = ACC_W'(sum - {1'b0, modulus});
                next_bit_tick = 1'b1;
            end else begin
                next_acc = sum[ACC_W-1:0];
            end
        end else begin
            next_ref_cnt = ref_cnt + 4'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_cnt  <= 4'd0;
            acc      <= '0;
            bit_tick <= 1'b0;
        end else begin
            ref_cnt  <= next_ref_cnt;
            acc      <= next_acc;
            bit_tick <= next_bit_tick;
        end
    end
endmodule : rfafc_rate_gen

// ==== verilog/rfafc_top.sv ====
`timescale 1ns/1ps
`include "rfafc_consts.svh"
module rfafc_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tx_req,
    input  wire logic        rx_req,
    input  wire logic        tx_fifo_mode,
    input  wire logic        tx_packet_active,
    input  wire logic        rx_multi_packet,
    input  wire logic        preamble_detect,
    input  wire logic        packet_end,
    input  wire logic        tune_done,
    input  wire logic signed [7:0] freq_error,
    output rfafc_pkg::rfafc_state_t radio_state,
    output logic             synth_retune,
    output logic [15:0]      hop_offset_10khz,
    output logic signed [11:0] lo_offset_word,
    output logic [9:0]       deviation_hz_625,
    output logic             out_div2_bypass,
    output logic             tx_bit_tick
);
    import rfafc_pkg::*;

    // =====================================================================
    // Register file
    logic [7:0] rate_hi, rate_lo, rate_scale_reg, modctl2, dev_lo, ofs_lo, ofs_hi;
    logic [7:0] band, hop_ch, hop_step, afc_gear, afc_timing, pull_in_limit;
    logic [7:0] next_reg_rdata;
    logic       hop_write;
    logic signed [7:0] afc_corr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rate_hi        <= `RFAFC_RST_RATE_HI;
            rate_lo        <= `RFAFC_RST_RATE_LO;
            rate_scale_reg <= 8'h00;
            modctl2        <= `RFAFC_RST_MODCTL2;
            dev_lo         <= `RFAFC_RST_DEV_LO;
            ofs_lo         <= `RFAFC_RST_OFS;
            ofs_hi         <= `RFAFC_RST_OFS;
            band           <= `RFAFC_RST_BAND;
            hop_ch         <= 8'h00;
            hop_step       <= 8'h00;
            afc_gear       <= `RFAFC_RST_AFC_GEAR;
            afc_timing     <= `RFAFC_RST_AFC_TIMING;
            pull_in_limit  <= `RFAFC_RST_LIMIT;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RFAFC_ADDR_RATE_HI:    rate_hi        <= reg_wdata;
                `RFAFC_ADDR_RATE_LO:    rate_lo        <= reg_wdata;
                `RFAFC_ADDR_RATE_SCALE: rate_scale_reg <= reg_wdata;
                `RFAFC_ADDR_MODCTL2:    modctl2        <= reg_wdata;
                `RFAFC_ADDR_DEV_LO:     dev_lo         <= reg_wdata;
                `RFAFC_ADDR_OFS_LO:     ofs_lo         <= reg_wdata;
                `RFAFC_ADDR_OFS_HI:     ofs_hi         <= {6'h00, reg_wdata[1:0]};
                `RFAFC_ADDR_BAND:       band           <= reg_wdata;
                `RFAFC_ADDR_HOP_CH:     hop_ch         <= reg_wdata;
                `RFAFC_ADDR_HOP_STEP:   hop_step       <= reg_wdata;
                `RFAFC_ADDR_AFC_GEAR:   afc_gear       <= reg_wdata;
                `RFAFC_ADDR_AFC_TIMING: afc_timing     <= reg_wdata;
                `RFAFC_ADDR_LIMIT:      pull_in_limit  <= reg_wdata;
                default: ;
            endcase
        end
    end

    assign hop_write = reg_wr && (reg_addr == `RFAFC_ADDR_HOP_CH || reg_addr == `RFAFC_ADDR_HOP_STEP);

    always_comb begin
        unique case (reg_addr)
            `RFAFC_ADDR_RATE_HI:    next_reg_rdata = rate_hi;
            `RFAFC_ADDR_RATE_LO:    next_reg_rdata = rate_lo;
            `RFAFC_ADDR_RATE_SCALE: next_reg_rdata = rate_scale_reg;
            `RFAFC_ADDR_MODCTL2:    next_reg_rdata = modctl2;
            `RFAFC_ADDR_DEV_LO:     next_reg_rdata = dev_lo;
            `RFAFC_ADDR_OFS_LO:     next_reg_rdata = ofs_lo;
            `RFAFC_ADDR_OFS_HI:     next_reg_rdata = ofs_hi;
            `RFAFC_ADDR_BAND:       next_reg_rdata = band;
            `RFAFC_ADDR_HOP_CH:     next_reg_rdata = hop_ch;
            `RFAFC_ADDR_HOP_STEP:   next_reg_rdata = hop_step;
            `RFAFC_ADDR_AFC_GEAR:   next_reg_rdata = afc_gear;
            `RFAFC_ADDR_AFC_TIMING: next_reg_rdata = afc_timing;
            `RFAFC_ADDR_LIMIT:      next_reg_rdata = pull_in_limit;
            `RFAFC_ADDR_CORR:       next_reg_rdata = afc_corr;
            default:                next_reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= next_reg_rdata;
    end

    // =====================================================================
    // Radio state with automatic retune on hop change
    rfafc_state_t state, next_state, return_state, next_return_state;
    logic         hop_pending, next_hop_pending, next_synth_retune;

    always_comb begin
        next_state        = state;
        next_return_state = return_state;
        next_hop_pending  = hop_pending || hop_write;
        next_synth_retune = 1'b0;
        unique case (state)
            RFAFC_IDLE: begin
                if (tx_req || rx_req) begin
                    next_state        = RFAFC_TUNE;
                    next_return_state = tx_req ? RFAFC_TX : RFAFC_RX;
                    next_synth_retune = 1'b1;
                    next_hop_pending  = 1'b0;
                end
            end
            RFAFC_TUNE: begin
                if (tune_done) next_state = return_state;
            end
            RFAFC_TX, RFAFC_RX: begin
                if (state == RFAFC_TX ? !tx_req : !rx_req) begin
                    next_state = RFAFC_IDLE;
                end else if (next_hop_pending &&
                             !(state == RFAFC_TX && tx_fifo_mode && tx_packet_active)) begin
                    next_state        = RFAFC_TUNE;
                    next_return_state = state;
                    next_synth_retune = 1'b1;
                    next_hop_pending  = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state        <= RFAFC_IDLE;
            return_state <= RFAFC_TX;
            hop_pending  <= 1'b0;
            synth_retune <= 1'b0;
        end else begin
            state        <= next_state;
            return_state <= next_return_state;
            hop_pending  <= next_hop_pending;
            synth_retune <= next_synth_retune;
        end
    end

    // =====================================================================
    // TX bit clock, running only in TX
    logic bit_tick;
    rfafc_rate_gen #(.ACC_W(22)) u_rate (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .enable     (state == RFAFC_TX),
        .rate_word  ({rate_hi, rate_lo}),
        .rate_scale (rate_scale_reg[`RFAFC_SCALE_BIT]),
        .bit_tick   (bit_tick)
    );

    // =====================================================================
    // AFC loop, stepped on ticks of a fixed receive bit rate
    rfafc_afc_t        afc_st, next_afc_st;
    logic [3:0]        bit_cnt, next_bit_cnt;
    logic signed [7:0] next_afc_corr;
    logic              frozen, next_frozen;
    logic              afc_en;
    logic [2:0]        shwait, gear;
    logic signed [9:0] lim, step, cand;
    logic              rx_tick;
    logic              bit_tick_rx;

    assign afc_en  = afc_timing[`RFAFC_AFC_EN_BIT];
    assign shwait  = afc_timing[2:0];
    assign gear    = afc_gear[5:3];
    assign rx_tick = (state == RFAFC_RX) && bit_tick_rx;

    // Transmit rate word kept out of receive timing
    rfafc_rate_gen #(.ACC_W(22)) u_rx_rate (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .enable     (state == RFAFC_RX),
        .rate_word  (`RFAFC_RX_RATE_WORD),
        .rate_scale (`RFAFC_RX_RATE_SCALE),
        .bit_tick   (bit_tick_rx)
    );

    always_comb begin
        next_afc_st   = afc_st;
        next_bit_cnt  = bit_cnt;
        next_afc_corr = afc_corr;
        next_frozen   = frozen || preamble_detect;
        // Four correction steps per limiter count, band factor cancels
        lim  = (pull_in_limit > `RFAFC_LIMIT_MAX) ? `RFAFC_CORR_MAX
                                                  : $signed({pull_in_limit, 2'b00});
        step = $signed({{2{freq_error[7]}}, freq_error}) >>> gear;
        cand = $signed({{2{afc_corr[7]}}, afc_corr}) + step;
        if (state != RFAFC_RX || !afc_en) begin
            next_afc_st  = RFAFC_MEAS;
            next_bit_cnt = 4'd0;
            next_frozen  = 1'b0;
        end else if (packet_end) begin
            next_frozen = 1'b0;
            next_afc_st = RFAFC_MEAS;
            next_bit_cnt = 4'd0;
            if (rx_multi_packet) next_afc_corr = 8'sd0;
        end else if (!frozen && !preamble_detect && rx_tick) begin
            unique case (afc_st)
                RFAFC_MEAS: begin
                    next_bit_cnt = bit_cnt + 4'd1;
                    if (bit_cnt + 4'd1 == `RFAFC_MEAS_BITS) begin
                        next_afc_st  = RFAFC_APPLY;
                        next_bit_cnt = 4'd0;
                    end
                end
                RFAFC_APPLY: begin
                    if (shwait != 3'd0) begin
                        if (cand > lim) next_afc_corr = lim[7:0];
                        else if (cand < -lim) next_afc_corr = 8'(-lim);
                        else next_afc_corr = cand[7:0];
                    end
                    next_afc_st = RFAFC_SETTLE;
                end
                RFAFC_SETTLE: begin
                    next_bit_cnt = bit_cnt + 4'd1;
                    if (bit_cnt + 4'd1 >= {shwait, 1'b0} - 4'd1 || shwait == 3'd0) begin
                        next_afc_st  = RFAFC_MEAS;
                        next_bit_cnt = 4'd0;
                    end
                end
                RFAFC_HOLD: next_afc_st = RFAFC_MEAS;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            afc_st   <= RFAFC_MEAS;
            bit_cnt  <= 4'd0;
            afc_corr <= 8'sd0;
            frozen   <= 1'b0;
        end else begin
            afc_st   <= next_afc_st;
            bit_cnt  <= next_bit_cnt;
            afc_corr <= next_afc_corr;
            frozen   <= next_frozen;
        end
    end

    // =====================================================================
    // Synthesizer words
    logic signed [11:0] next_lo_offset;
    logic signed [9:0]  manual_offset_word;
    assign manual_offset_word = $signed({ofs_hi[1:0], ofs_lo});

    always_comb begin
        if (state == RFAFC_RX && afc_en)
            next_lo_offset = {{4{afc_corr[7]}}, afc_corr};
        else
            next_lo_offset = {{2{manual_offset_word[9]}}, manual_offset_word};
        if (band[`RFAFC_HBSEL_BIT]) next_lo_offset = next_lo_offset <<< 1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            radio_state      <= RFAFC_IDLE;
            hop_offset_10khz <= 16'h0000;
            lo_offset_word   <= 12'sd0;
            deviation_hz_625 <= 10'h000;
            out_div2_bypass  <= 1'b0;
            tx_bit_tick      <= 1'b0;
        end else begin
            radio_state      <= state;
            // Carrier held while transmitting or receiving, taken up in idle and tune
            if (state != RFAFC_TX && state != RFAFC_RX) begin
                hop_offset_10khz <= 16'(hop_step) * 16'(hop_ch);
            end
            lo_offset_word   <= next_lo_offset;
            deviation_hz_625 <= {1'b0, modctl2[`RFAFC_DEV_MSB_BIT], dev_lo};
            out_div2_bypass  <= band[`RFAFC_HBSEL_BIT];
            tx_bit_tick      <= bit_tick;
        end
    end
endmodule : rfafc_top

// ==== testbench/rfafc_top_asserts.sv ====
`timescale 1ns/1ps
module rfafc_top_asserts (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [6:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  tx_req,
    input wire logic                  tx_fifo_mode,
    input wire logic                  tx_packet_active,
    input wire logic                  tune_done,
    input wire rfafc_pkg::rfafc_state_t radio_state,
    input wire logic                  synth_retune,
    input wire logic [9:0]            deviation_hz_625,
    input wire logic                  out_div2_bypass,
    input wire logic                  tx_bit_tick
);
    import rfafc_pkg::*;
    // ==========================================
    // Port relations
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_retune_one_cycle: assert property (synth_retune |=> !synth_retune)
        else $error("retune pulse too long");
    a_hop_write_retunes: assert property (reg_wr && reg_addr inside {7'h79, 7'h7a} && !synth_retune
        && radio_state inside {RFAFC_TX, RFAFC_RX} && !(tx_fifo_mode && tx_packet_active) |=> synth_retune)
        else $error("hop write gave no retune");
    a_packet_not_cut: assert property (tx_fifo_mode && tx_packet_active && radio_state == RFAFC_TX
        |-> !synth_retune) else $error("retune during packet");
    a_retune_to_tune: assert property (synth_retune |=> radio_state == RFAFC_TUNE)
        else $error("retune without tune state");
    a_tune_back_tx: assert property (radio_state == RFAFC_TUNE && tune_done && tx_req
        |-> ##2 radio_state == RFAFC_TX) else $error("no return to transmit");
    a_band_bypass: assert property (reg_wr && reg_addr == 7'h75
        |-> ##2 out_div2_bypass == $past(reg_wdata[5], 2)) else $error("bypass differs from band bit");
    a_dev_low_byte: assert property (reg_wr && reg_addr == 7'h72
        |-> ##2 deviation_hz_625[7:0] == $past(reg_wdata, 2)) else $error("deviation low byte wrong");
    a_dev_top_bit: assert property (reg_wr && reg_addr == 7'h71
        |-> ##2 deviation_hz_625[9:8] == {1'b0, $past(reg_wdata[2], 2)}) else $error("deviation top bit wrong");
    a_no_tick_rx: assert property (radio_state == RFAFC_RX |-> !tx_bit_tick)
        else $error("bit tick in receive");
    a_offset_hi_mask: assert property (reg_rd && reg_addr == 7'h74 |=> reg_rdata[7:2] == 6'h00)
        else $error("offset high bits set");
    a_tick_spacing: assert property (tx_bit_tick |=> !tx_bit_tick [*8])
        else $error("bit ticks too close");
endmodule : rfafc_top_asserts

// ==== testbench/rfafc_host_model.sv ====
`timescale 1ns/1ps
module rfafc_host_model (
    input wire logic       sys_clk,
    output logic           reg_wr,
    output logic           reg_rd,
    output logic [6:0]     reg_addr,
    output logic [7:0]     reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // ==========================================
    // Register port master
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // Released data is not left valid
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd
endmodule : rfafc_host_model

// ==== testbench/tb_rfafc_top.sv ====
`timescale 1ns/1ps
module tb_rfafc_top;
    import rfafc_pkg::*;
    logic               sys_clk, rst, reg_wr, reg_rd, tx_req, rx_req, tx_fifo_mode, tx_packet_active;
    logic               rx_multi_packet, preamble_detect, packet_end, tune_done, synth_retune;
    logic               out_div2_bypass, tx_bit_tick;
    logic [6:0]         reg_addr;
    logic [7:0]         reg_wdata, reg_rdata;
    logic signed [7:0]  freq_error;
    rfafc_state_t       radio_state;
    logic [15:0]        hop_offset_10khz;
    logic signed [11:0] lo_offset_word;
    logic [9:0]         deviation_hz_625;
    logic [7:0]         v8;
    int                 fail_count = 0, compares = 0, retunes = 0, ticks = 0, r0, t0;
    logic [6:0]         rst_a [6] = '{7'h6e, 7'h6f, 7'h71, 7'h72, 7'h73, 7'h74};
    logic [7:0]         rst_v [6] = '{8'h0a, 8'h3d, 8'h00, 8'h20, 8'h00, 8'h00};
    rfafc_top u_rfafc_top (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .tx_req,
        .rx_req, .tx_fifo_mode, .tx_packet_active, .rx_multi_packet, .preamble_detect, .packet_end,
        .tune_done, .freq_error, .radio_state, .synth_retune, .hop_offset_10khz, .lo_offset_word,
        .deviation_hz_625, .out_div2_bypass, .tx_bit_tick);
    rfafc_host_model u_rfafc_host_model (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // ==========================================
    // Clock and event counters
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        retunes <= retunes + int'(synth_retune === 1'b1);
        ticks <= ticks + int'(tx_bit_tick === 1'b1);
    end
    // ==========================================
    // Tasks
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_rfafc_host_model.wr(a, d);
    endtask : wr
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_rfafc_host_model.rd(a, v);
        chk($sformatf("reg %h", a), {8'h00, v}, {8'h00, e});
    endtask : rchk
    task automatic wait_st(input rfafc_state_t s);
        bit sent;
        int n;
        sent = 1'b0;
        for (n = 0; n < 300 && radio_state !== s; n++) begin
            @(posedge sys_clk);
            tune_done <= (radio_state == RFAFC_TUNE) && !sent && s != RFAFC_TUNE;
            sent = sent || (radio_state == RFAFC_TUNE);
        end
        if (n == 300) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : wait_st
    task automatic pulse(input bit pe);
        @(posedge sys_clk);
        packet_end <= pe;
        preamble_detect <= !pe;
        @(posedge sys_clk);
        packet_end <= 1'b0;
        preamble_detect <= 1'b0;
    endtask : pulse
    // ==========================================
    // Main sequence
    initial begin
        {rst, tx_req, rx_req, tx_fifo_mode, tx_packet_active, rx_multi_packet} = 6'h20;
        {preamble_detect, packet_end, tune_done, freq_error} = 11'h000;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rst_a[i]) rchk(rst_a[i], rst_v[i]);
        chk("dev", {6'h0, deviation_hz_625}, 16'h0020);
        wr(7'h71, 8'h04);
        wr(7'h72, 8'hff);
        rchk(7'h71, 8'h04);
        chk("dev", {6'h0, deviation_hz_625}, 16'h01ff);
        wr(7'h74, 8'hff);
        rchk(7'h74, 8'h03);
        wr(7'h58, 8'hc0);
        rchk(7'h58, 8'h00);
        wr(7'h73, 8'h60);
        wr(7'h74, 8'h03);
        repeat (2) @(posedge sys_clk);
        chk("lo", {4'h0, lo_offset_word}, 16'h0ec0);
        wr(7'h75, 8'h15);
        repeat (2) @(posedge sys_clk);
        chk("lo", {4'h0, lo_offset_word}, 16'h0f60);
        chk("bypass", {15'h0, out_div2_bypass}, 16'h0000);
        wr(7'h75, 8'h35);
        wr(7'h7a, 8'h03);
        wr(7'h79, 8'h05);
        repeat (2) @(posedge sys_clk);
        chk("hop", hop_offset_10khz, 16'h000f);
        chk("bypass", {15'h0, out_div2_bypass}, 16'h0001);
        wr(7'h1e, 8'h41);
        wr(7'h6e, 8'h40);
        wr(7'h6f, 8'h00);
        wr(7'h70, 8'h00);
        tx_req <= 1'b1;
        wait_st(RFAFC_TX);
        chk("lo", {4'h0, lo_offset_word}, 16'h0ec0);
        t0 = ticks;
        repeat (4000) @(posedge sys_clk);
        chk("ticks", {15'h0, ticks - t0 >= 99 && ticks - t0 <= 101}, 16'h0001);
        r0 = retunes;
        wr(7'h79, 8'h06);
        wait_st(RFAFC_TUNE);
        wait_st(RFAFC_TX);
        chk("retunes", 16'(retunes - r0), 16'h0001);
        chk("hop", hop_offset_10khz, 16'h0012);
        tx_fifo_mode <= 1'b1;
        tx_packet_active <= 1'b1;
        r0 = retunes;
        wr(7'h79, 8'h07);
        repeat (20) @(posedge sys_clk);
        chk("retunes", 16'(retunes - r0), 16'h0000);
        chk("hop", hop_offset_10khz, 16'h0012);
        tx_packet_active <= 1'b0;
        wait_st(RFAFC_TUNE);
        wait_st(RFAFC_TX);
        chk("hop", hop_offset_10khz, 16'h0015);
        tx_fifo_mode <= 1'b0;
        wr(7'h6e, 8'h80);
        wr(7'h70, 8'h20);
        t0 = ticks;
        repeat (6400) @(posedge sys_clk);
        chk("ticks", {15'h0, ticks - t0 >= 9 && ticks - t0 <= 11}, 16'h0001);
        tx_req <= 1'b0;
        wait_st(RFAFC_IDLE);
        rx_req <= 1'b1;
        rx_multi_packet <= 1'b1;
        freq_error <= 8'sd100;
        wr(7'h2a, 8'h02);
        wait_st(RFAFC_RX);
        wr(7'h79, 8'h08);
        wait_st(RFAFC_TUNE);
        wait_st(RFAFC_RX);
        chk("hop", hop_offset_10khz, 16'h0018);
        t0 = ticks;
        repeat (8000) @(posedge sys_clk);
        chk("ticks", 16'(ticks - t0), 16'h0000);
        rchk(7'h2b, 8'h08);
        chk("lo", {4'h0, lo_offset_word}, 16'h0010);
        pulse(1'b0);
        freq_error <= -8'sd100;
        repeat (8000) @(posedge sys_clk);
        rchk(7'h2b, 8'h08);
        pulse(1'b1);
        rchk(7'h2b, 8'h00);
        repeat (8000) @(posedge sys_clk);
        rchk(7'h2b, 8'hf8);
        // One step of -1 per four-tick cycle, about ten cycles
        freq_error <= -8'sd8;
        wr(7'h1d, 8'h18);
        wr(7'h2a, 8'h1f);
        pulse(1'b1);
        repeat (1600) @(posedge sys_clk);
        u_rfafc_host_model.rd(7'h2b, v8);
        chk("gear", {15'h0, v8 inside {[8'hf5:8'hf7]}}, 16'h0001);
        wr(7'h1e, 8'h40);
        pulse(1'b1);
        repeat (8000) @(posedge sys_clk);
        rchk(7'h2b, 8'h00);
        tally_and_finish();
    end
endmodule : tb_rfafc_top
bind rfafc_top rfafc_top_asserts u_rfafc_top_asserts (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .tx_req, .tx_fifo_mode, .tx_packet_active, .tune_done, .radio_state, .synth_retune,
    .deviation_hz_625, .out_div2_bypass, .tx_bit_tick);
